// ===== core/rtc_tamper_pkg.sv
// Summary of operation
// [RQ1] Narrow counter writes below access width are dropped.
// [RQ2] Software writes 32-bit and calendar counts whole.
// [RQ3] Software writes 16-bit counts as one halfword.
// [RQ4] First synchronized count read returns a stale value.
// [RQ5] Software rereads count until it changes.
// [RQ6] Majority debounce enable has no effect.
// [RQ7] Enabling tamper detection may report a false event.
// [RQ8] Software uses falling edges or drops first event.
// [RQ9] External reset mid-detection skips next timestamp capture.
// [RQ10] Software copies count to storage in tamper handler.
// [RQ11] Periodic events run with prescaler off during tamper.
// [RQ12] Software disables periodic enables when prescaler off.
// [RQ13] Tamper flag clears only by writing one.
// [RQ14] General stores clear on every tamper detection.
// [RQ15] Tamper sets flag and captures the count.
package rtc_tamper_pkg;

    typedef enum logic [1:0] {
        mode_thirtytwo_bit_counter,
        mode_sixteen_bit_counter,
        mode_calendar
    } count_mode_t;

    typedef enum logic [1:0] {
        access_byte,
        access_half,
        access_word
    } access_size_t;

    localparam int          CLOCK_HZ       = 40_000_000;
    // Base tick period of the slow counting time base.
    localparam int          BASE_TICK_NS   = 30518;
    localparam int          BASE_TICK_CYC  = (BASE_TICK_NS * (CLOCK_HZ / 1_000_000)) / 1000;
    localparam int          BASE_W         = 11;
    localparam int          PSC_W          = 16;
    localparam int          PRESCALER_W    = 4;
    localparam int          PER_N          = 8;
    localparam int          TAMPER_N       = 4;
    localparam int          DEB_LEN        = 3;
    localparam int          DEB_W          = 2;
    localparam int          GP_WORDS       = 4;
    localparam int          GP_AW          = 2;
    localparam logic [31:0] COUNT_RST      = 32'h0000_0000;
    localparam logic [31:0] TIMESTAMP_RST  = 32'h0000_0000;
    localparam logic [31:0] GP_RST         = 32'h0000_0000;

endpackage : rtc_tamper_pkg

// ===== core/gp_store_if.sv
`timescale 1ns/10ps
interface gp_store_if #(
    parameter int AW = 2
);
    logic          wr_en;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic [AW-1:0] rd_addr;
    logic [31:0]   rdata;
    logic          clear;

    modport mem  (input wr_en, addr, wdata, rd_addr, clear, output rdata);
    modport user (output wr_en, addr, wdata, rd_addr, clear, input rdata);
endinterface : gp_store_if

// ===== core/gp_store_mem.sv
`timescale 1ns/10ps
module gp_store_mem
    import rtc_tamper_pkg::*;
#(
    parameter int WORDS = GP_WORDS
) (
    input  wire logic  i_clock,  // System clock.
    input  wire logic  i_rstn,   // Synchronised reset, active low.
    gp_store_if.mem    port      // Store access.
);
    logic [WORDS-1:0][31:0] mem_r;
    logic [31:0]            rdata_r;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_r   <= {WORDS{GP_RST}};
            rdata_r <= GP_RST;
        end else begin
            if (port.clear) begin
                mem_r <= {WORDS{GP_RST}}; // [RQ14]
            end else if (port.wr_en) begin
                mem_r[port.addr] <= port.wdata;
            end
            rdata_r <= mem_r[port.rd_addr];
        end
    end

    assign port.rdata = rdata_r;
endmodule : gp_store_mem

// ===== core/rtc_counter_tamper.sv
`timescale 1ns/10ps
module rtc_counter_tamper
    import rtc_tamper_pkg::*;
#(
    parameter int TAMPERS = TAMPER_N
) (
    input  wire logic                   i_clock,                       // 40 MHz clock.
    input  wire logic                   i_rstn,                        // Async reset, low.
    input  wire count_mode_t            i_mode,                        // Counting mode.
    input  wire logic [PRESCALER_W-1:0] i_prescaler,                   // 0 is off.
    input  wire logic                   i_count_wr,                    // Count write strobe.
    input  wire access_size_t           i_count_wr_size,               // Write width.
    input  wire logic [31:0]            i_count_wdata,                 // Count write data.
    input  wire logic                   i_counter_read_sync_enable,    // Read sync on.
    input  wire logic                   i_count_rd_req,                // Read snapshot strobe.
    input  wire logic [PER_N-1:0]       i_periodic_event_output_enable,// Event enables.
    input  wire logic [PER_N-1:0]       i_periodic_irq_enable,         // Irq enables.
    input  wire logic                   i_tamper_en,                   // Detection on.
    input  wire logic                   i_debounce_en,                 // Debounce on.
    input  wire logic                   i_debounce_majority_enable,    // Majority on.
    input  wire logic [TAMPERS-1:0]     i_tamper_rising,               // 1 rising, 0 falling.
    input  wire logic [TAMPERS-1:0]     i_tamper_pin,                  // Tamper pins.
    input  wire logic                   i_ext_reset,                   // External reset pin.
    input  wire logic                   i_tamper_flag_clr,             // Write one to clear.
    input  wire logic                   i_general_store_reset_on_tamper, // Store reset select.
    input  wire logic                   i_gp_wr,                       // Store write.
    input  wire logic [GP_AW-1:0]       i_gp_addr,                     // Store write address.
    input  wire logic [31:0]            i_gp_wdata,                    // Store write data.
    input  wire logic [GP_AW-1:0]       i_gp_rd_addr,                  // Store read address.
    output logic [31:0]                 o_gp_rdata,                    // Store read data.
    output logic [31:0]                 o_count,                       // Live count.
    output logic [31:0]                 o_count_rd,                    // Count for reading.
    output logic [31:0]                 o_timestamp,                   // Captured count.
    output logic                        o_tamper_flag,                 // Sticky tamper flag.
    output logic [PER_N-1:0]            o_periodic_event,              // Event pulses.
    output logic [PER_N-1:0]            o_periodic_interval_irq        // Irq pulses.
);

    typedef struct packed {
        logic [TAMPERS-1:0]            tp_meta;
        logic [TAMPERS-1:0]            tp_sync;
        logic [TAMPERS-1:0]            tp_level;
        logic [TAMPERS-1:0][DEB_W-1:0] deb_cnt;
        logic                          xr_meta;
        logic                          xr_sync;
        logic                          ts_block;
        logic [BASE_W-1:0]             base_cnt;
        logic [PSC_W-1:0]              psc_cnt;
        logic [31:0]                   count;
        logic                          sync_en_d;
        logic                          sync_first;
        logic [31:0]                   count_rd;
        logic [31:0]                   timestamp;
        logic                          tamper_flag;
        logic [PER_N-1:0]              per_evt;
        logic [PER_N-1:0]              per_irq;
    } state_t;

    localparam state_t STATE_RST = '{
        count:     COUNT_RST,
        count_rd:  COUNT_RST,
        timestamp: TIMESTAMP_RST,
        default:   '0
    };

    // Low bits that must be zero for a counter tick at a prescaler setting.
    function automatic logic [PSC_W-1:0] div_mask(input logic [PRESCALER_W-1:0] psc);
        logic [PSC_W-1:0] m;
        m = '0;
        for (int b = 0; b < PSC_W; b++) begin
            if (32'(b) < 32'(psc) - 1) begin
                m[b] = 1'b1;
            end
        end
        return m;
    endfunction : div_mask

    logic [1:0]  rst_pipe_r;
    logic        rstn_sync;
    state_t      s_r;
    state_t      s_nxt;
    logic        base_tick;
    logic        psc_run;
    logic        in_progress;
    logic        block_set;
    logic [TAMPERS-1:0] detect;
    logic [PSC_W-1:0]   psc_rise;
    logic        gp_clear;

    gp_store_if #(.AW(GP_AW)) gp_bus ();

    gp_store_mem #(.WORDS(GP_WORDS)) u_gp_store (
        .i_clock (i_clock),
        .i_rstn  (rstn_sync),
        .port    (gp_bus.mem)
    );

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rstn_sync = rst_pipe_r[1];

    always_comb begin
        s_nxt       = s_r;
        detect      = '0;
        psc_rise    = '0;
        in_progress = 1'b0;
        block_set   = 1'b0;
        gp_clear    = 1'b0;

        s_nxt.tp_meta   = i_tamper_pin;
        s_nxt.tp_sync   = s_r.tp_meta;
        s_nxt.xr_meta   = i_ext_reset;
        s_nxt.xr_sync   = s_r.xr_meta;
        s_nxt.sync_en_d = i_counter_read_sync_enable;
        s_nxt.per_evt   = '0;
        s_nxt.per_irq   = '0;

        base_tick      = (s_r.base_cnt == BASE_W'(BASE_TICK_CYC - 1));
        s_nxt.base_cnt = base_tick ? '0 : s_r.base_cnt + 1'b1;

        // The divider keeps running for the tamper logic even with the prescaler off,
        // so its taps still raise periodic events then.
        psc_run = (i_prescaler != '0) || i_tamper_en || i_debounce_en; // [RQ11]
        if (base_tick && psc_run) begin
            s_nxt.psc_cnt = s_r.psc_cnt + 1'b1;
            psc_rise      = s_nxt.psc_cnt & ~s_r.psc_cnt;
            s_nxt.per_evt = psc_rise[PER_N-1:0] & i_periodic_event_output_enable; // [RQ11]
            s_nxt.per_irq = psc_rise[PER_N-1:0] & i_periodic_irq_enable; // [RQ11]
            if (i_prescaler != '0 && (s_nxt.psc_cnt & div_mask(i_prescaler)) == '0) begin
                if (i_mode == mode_sixteen_bit_counter) begin
                    s_nxt.count = {16'h0000, s_r.count[15:0] + 16'h0001};
                end else begin
                    s_nxt.count = s_r.count + 32'h0000_0001;
                end
            end
        end

        // Writes narrower than the register width are lost.
        if (i_count_wr) begin
            if (i_mode == mode_sixteen_bit_counter) begin
                if (i_count_wr_size != access_byte) begin // [RQ1]
                    s_nxt.count = {16'h0000, i_count_wdata[15:0]};
                end
            end else if (i_count_wr_size == access_word) begin // [RQ1]
                s_nxt.count = i_count_wdata;
            end
        end

        // The first snapshot after enabling sync keeps the stale held value.
        if (i_counter_read_sync_enable) begin
            if (!s_r.sync_en_d) begin
                s_nxt.sync_first = 1'b1;
            end
            if (i_count_rd_req) begin
                if (s_r.sync_first || !s_r.sync_en_d) begin
                    s_nxt.sync_first = 1'b0; // [RQ4]
                end else begin
                    s_nxt.count_rd = s_r.count;
                end
            end
        end else begin
            s_nxt.sync_first = 1'b0;
            s_nxt.count_rd   = s_r.count;
        end

        // The majority enable is not wired into the filter: plain run-length debounce only.
        for (int i = 0; i < TAMPERS; i++) begin // [RQ6]
            in_progress = in_progress || (s_r.deb_cnt[i] != '0);
            if (!i_tamper_en) begin
                // Level parks low while disabled, so a high pin looks like a rising edge on enable.
                s_nxt.tp_level[i] = 1'b0; // [RQ7]
                s_nxt.deb_cnt[i]  = '0;
            end else if (!i_debounce_en) begin
                s_nxt.tp_level[i] = s_r.tp_sync[i];
            end else if (s_r.tp_sync[i] == s_r.tp_level[i]) begin
                s_nxt.deb_cnt[i] = '0;
            end else if (base_tick) begin
                if (s_r.deb_cnt[i] == DEB_W'(DEB_LEN - 1)) begin
                    s_nxt.tp_level[i] = s_r.tp_sync[i];
                    s_nxt.deb_cnt[i]  = '0;
                end else begin
                    s_nxt.deb_cnt[i] = s_r.deb_cnt[i] + 1'b1;
                end
            end
            detect[i] = i_tamper_en && (s_nxt.tp_level[i] != s_r.tp_level[i]) &&
                        (s_nxt.tp_level[i] == i_tamper_rising[i]); // [RQ7]
        end

        if (s_r.xr_sync) begin
            s_nxt.deb_cnt = '0;
            block_set     = in_progress; // [RQ9]
        end

        if (i_tamper_flag_clr) begin
            s_nxt.tamper_flag = 1'b0; // [RQ13]
        end
        if (|detect) begin
            s_nxt.tamper_flag = 1'b1; // [RQ15]
            gp_clear          = 1'b1; // [RQ14]
            if (!s_r.ts_block) begin
                s_nxt.timestamp = s_r.count; // [RQ15]
            end
        end
        s_nxt.ts_block = block_set || (s_r.ts_block && !(|detect)); // [RQ9]
    end

    always_ff @(posedge i_clock or negedge rstn_sync) begin
        if (!rstn_sync) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // The store reset select is ignored: every detection clears the stores.
    assign gp_bus.clear   = gp_clear || (1'b0 && i_general_store_reset_on_tamper); // [RQ14]
    assign gp_bus.wr_en   = i_gp_wr;
    assign gp_bus.addr    = i_gp_addr;
    assign gp_bus.wdata   = i_gp_wdata;
    assign gp_bus.rd_addr = i_gp_rd_addr;

    assign o_gp_rdata              = gp_bus.rdata;
    assign o_count                 = s_r.count;
    assign o_count_rd              = s_r.count_rd;
    assign o_timestamp             = s_r.timestamp;
    assign o_tamper_flag           = s_r.tamper_flag;
    assign o_periodic_event        = s_r.per_evt;
    assign o_periodic_interval_irq = s_r.per_irq;

    logic unused_majority;
    assign unused_majority = i_debounce_majority_enable;

endmodule : rtc_counter_tamper

// ===== bench/rtc_counter_tamper_asserts.sv
`timescale 1ns/10ps
module rtc_counter_tamper_asserts
    import rtc_tamper_pkg::*;
(
    input wire logic                   i_clock,                        // Clock.
    input wire logic                   i_rstn,                         // Reset.
    input wire count_mode_t            i_mode,                         // Mode.
    input wire logic [PRESCALER_W-1:0] i_prescaler,                    // Prescaler.
    input wire logic                   i_count_wr,                     // Write.
    input wire access_size_t           i_count_wr_size,                // Width.
    input wire logic [31:0]            i_count_wdata,                  // Data.
    input wire logic                   i_counter_read_sync_enable,     // Sync.
    input wire logic                   i_count_rd_req,                 // Read.
    input wire logic [PER_N-1:0]       i_periodic_event_output_enable, // Events.
    input wire logic [PER_N-1:0]       i_periodic_irq_enable,          // Irqs.
    input wire logic                   i_tamper_en,                    // Detect.
    input wire logic                   i_tamper_flag_clr,              // Clear.
    input wire logic [31:0]            o_gp_rdata,                     // Store.
    input wire logic [31:0]            o_count,                        // Count.
    input wire logic [31:0]            o_count_rd,                     // Read.
    input wire logic [31:0]            o_timestamp,                    // Stamp.
    input wire logic                   o_tamper_flag,                  // Flag.
    input wire logic [PER_N-1:0]       o_periodic_event,               // Events.
    input wire logic [PER_N-1:0]       o_periodic_interval_irq         // Irqs.
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    property p_word_wr;
        i_count_wr && i_count_wr_size == access_word && i_mode != mode_sixteen_bit_counter
            |=> o_count == $past(i_count_wdata);
    endproperty
    a_word_wr: assert property (p_word_wr)
        else $error("word write not taken");
    property p_half16;
        i_count_wr && i_count_wr_size == access_half && i_mode == mode_sixteen_bit_counter
            |=> o_count == {16'h0000, $past(i_count_wdata[15:0])};
    endproperty
    a_half16: assert property (p_half16)
        else $error("halfword write not taken");
    property p_byte_drop;
        i_count_wr && i_count_wr_size == access_byte && i_prescaler == 4'h0 |=> $stable(o_count);
    endproperty
    a_byte_drop: assert property (p_byte_drop)
        else $error("byte write changed count");
    property p_stale;
        $rose(i_counter_read_sync_enable) && i_count_rd_req |=> $stable(o_count_rd);
    endproperty
    a_stale: assert property (p_stale)
        else $error("first synced read not stale");
    property p_follow;
        !i_counter_read_sync_enable |=> o_count_rd == $past(o_count);
    endproperty
    a_follow: assert property (p_follow)
        else $error("read copy not following count");
    property p_flag_hold;
        o_tamper_flag && !i_tamper_flag_clr |=> o_tamper_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("tamper flag dropped");
    property p_flag_clr;
        o_tamper_flag && i_tamper_flag_clr && !i_tamper_en && !$past(i_tamper_en, 3)
            |=> !o_tamper_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("tamper flag not cleared");
    property p_stamp;
        $changed(o_timestamp) |-> o_tamper_flag;
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("stamp moved without flag");
    property p_gp_clr;
        $rose(o_tamper_flag) |=> o_gp_rdata == GP_RST;
    endproperty
    a_gp_clr: assert property (p_gp_clr)
        else $error("store not cleared");
    property p_gate;
        i_periodic_event_output_enable == 8'h00 && i_periodic_irq_enable == 8'h00
            |=> o_periodic_event == 8'h00 && o_periodic_interval_irq == 8'h00;
    endproperty
    a_gate: assert property (p_gate)
        else $error("periodic pulse while disabled");
    c_flag: cover property ($rose(o_tamper_flag));
    c_event: cover property (o_periodic_event != 8'h00);
    c_stale: cover property ($rose(i_counter_read_sync_enable) && i_count_rd_req);
endmodule : rtc_counter_tamper_asserts

bind rtc_counter_tamper rtc_counter_tamper_asserts u_chk (.*);

// ===== bench/tb_rtc_counter_tamper.sv
`timescale 1ns/10ps
module tb_rtc_counter_tamper
    import rtc_tamper_pkg::*;
();
    logic i_clock = 1'b0, i_rstn = 1'b0, i_count_wr = 1'b0, i_counter_read_sync_enable = 1'b0;
    logic i_count_rd_req = 1'b0, i_tamper_en = 1'b0, i_debounce_en = 1'b0, i_ext_reset = 1'b0;
    logic i_debounce_majority_enable = 1'b0, i_tamper_flag_clr = 1'b0, i_gp_wr = 1'b0;
    logic i_general_store_reset_on_tamper = 1'b0;
    count_mode_t i_mode = mode_thirtytwo_bit_counter;
    access_size_t i_count_wr_size = access_word;
    logic [PRESCALER_W-1:0] i_prescaler = 4'h0;
    logic [31:0] i_count_wdata = 32'h0, i_gp_wdata = 32'h0, d;
    logic [PER_N-1:0] i_periodic_event_output_enable = 8'h00, i_periodic_irq_enable = 8'h00;
    logic [PER_N-1:0] o_periodic_event, o_periodic_interval_irq, seen;
    logic [TAMPER_N-1:0] i_tamper_rising = 4'h0, i_tamper_pin = 4'h0;
    logic [GP_AW-1:0] i_gp_addr = 2'h0, i_gp_rd_addr = 2'h0;
    logic [31:0] o_gp_rdata, o_count, o_count_rd, o_timestamp;
    logic o_tamper_flag;
    int num_errors = 0, n_tests = 0;

    rtc_counter_tamper uut (.*);

    always #12.5 i_clock = ~i_clock;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_count(input access_size_t s, input logic [31:0] v);
        i_count_wr_size = s;
        i_count_wdata = v;
        i_count_wr = 1'b1;
        @(negedge i_clock);
        i_count_wr = 1'b0;
        @(negedge i_clock);
    endtask : wr_count

    task automatic wait_flag(input int lim);
        for (int k = 0; k < lim && o_tamper_flag !== 1'b1; k++)
            @(negedge i_clock);
        check({31'h0, o_tamper_flag}, 32'h1);
        if (o_tamper_flag !== 1'b1)
            finish_test();
    endtask : wait_flag

    task automatic watch(input int n);
        seen = 8'h00;
        repeat (n) begin
            @(negedge i_clock);
            seen = seen | o_periodic_event | o_periodic_interval_irq;
        end
    endtask : watch

    initial begin
        repeat (4) @(negedge i_clock);
        i_rstn = 1'b1;
        repeat (3) @(negedge i_clock);
        // Word, halfword and byte writes in each counting mode.
        for (int m = 0; m < 3; m++) begin
            i_mode = count_mode_t'(m);
            d = 32'hA5C3_0F1E + 32'(m);
            wr_count(access_word, d);
            if (m == 1)
                d = {16'h0000, d[15:0]};
            check(o_count, d);
            wr_count(access_half, 32'h1234_5678);
            if (m == 1)
                d = 32'h0000_5678;
            check(o_count, d);
            wr_count(access_byte, 32'hFFFF_FF99);
            check(o_count, d);
        end
        i_mode = mode_thirtytwo_bit_counter;
        wr_count(access_word, 32'h0000_0100);
        check(o_count_rd, 32'h0000_0100);
        // Enable sync with a request while the count moves: the copy must stay stale.
        i_counter_read_sync_enable = 1'b1;
        i_count_rd_req = 1'b1;
        i_count_wdata = 32'h0000_0200;
        i_count_wr = 1'b1;
        @(negedge i_clock);
        i_count_wr = 1'b0;
        check(o_count_rd, 32'h0000_0100);
        @(negedge i_clock);
        i_count_rd_req = 1'b0;
        check(o_count_rd, 32'h0000_0200);
        wr_count(access_word, 32'h0000_0300);
        check(o_count_rd, 32'h0000_0200);
        i_count_rd_req = 1'b1;
        @(negedge i_clock);
        i_count_rd_req = 1'b0;
        check(o_count_rd, 32'h0000_0300);
        i_counter_read_sync_enable = 1'b0;
        // Prescaler off with detection on still makes periodic pulses.
        i_periodic_event_output_enable = 8'hFF;
        i_periodic_irq_enable = 8'hFF;
        i_tamper_en = 1'b1;
        watch(3000);
        check({31'h0, seen != 8'h00}, 32'h1);
        i_periodic_event_output_enable = 8'h00;
        i_periodic_irq_enable = 8'h00;
        watch(3000);
        check({24'h0, seen}, 32'h0);
        i_tamper_en = 1'b0;
        i_gp_addr = 2'h1;
        i_gp_rd_addr = 2'h1;
        i_gp_wdata = 32'hDEAD_BEEF;
        i_gp_wr = 1'b1;
        @(negedge i_clock);
        i_gp_wr = 1'b0;
        @(negedge i_clock);
        check(o_gp_rdata, 32'hDEAD_BEEF);
        // Enabling rising detection with the pin already high reports at once.
        i_tamper_rising = 4'h1;
        i_tamper_pin = 4'h1;
        i_tamper_en = 1'b1;
        wait_flag(50);
        repeat (2) @(negedge i_clock);
        check(o_timestamp, 32'h0000_0300);
        check(o_gp_rdata, GP_RST);
        repeat (20) @(negedge i_clock);
        check({31'h0, o_tamper_flag}, 32'h1);
        i_tamper_en = 1'b0;
        repeat (5) @(negedge i_clock);
        i_tamper_flag_clr = 1'b1;
        @(negedge i_clock);
        i_tamper_flag_clr = 1'b0;
        check({31'h0, o_tamper_flag}, 32'h0);
        // Falling-only detection with debounce; an external reset lands mid-debounce.
        wr_count(access_word, 32'h0000_0400);
        i_tamper_rising = 4'h0;
        i_debounce_en = 1'b1;
        i_debounce_majority_enable = 1'b1;
        i_tamper_en = 1'b1;
        repeat (5000) @(negedge i_clock);
        check({31'h0, o_tamper_flag}, 32'h0);
        i_tamper_pin = 4'h0;
        repeat (1500) @(negedge i_clock);
        i_ext_reset = 1'b1;
        repeat (4) @(negedge i_clock);
        i_ext_reset = 1'b0;
        wait_flag(8000);
        check(o_timestamp, 32'h0000_0300);
        // The handler keeps its own timestamp by copying the live count into a store word.
        i_gp_addr = 2'h2;
        i_gp_rd_addr = 2'h2;
        i_gp_wdata = o_count;
        i_gp_wr = 1'b1;
        @(negedge i_clock);
        i_gp_wr = 1'b0;
        @(negedge i_clock);
        check(o_gp_rdata, 32'h0000_0400);
        // With the prescaler on, a 16-bit count ticks and wraps within its own width.
        i_mode = mode_sixteen_bit_counter;
        wr_count(access_half, 32'h0000_FFFF);
        i_prescaler = 4'h1;
        for (int k = 0; k < 1300 && o_count == 32'h0000_FFFF; k++)
            @(negedge i_clock);
        check(o_count, 32'h0000_0000);
        finish_test();
    end
endmodule : tb_rtc_counter_tamper
